// File: include/ipf_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Bits 15 to 3 read zero, ignore writes
// - Bits 2 to 0 hold external interrupt 1 priority
// - Code 111 means priority level 7, highest
// - Code 001 means level 1; codes equal level
// - Code 000 disables source, never granted service
//////////////////////////////////////////////////////////////////////////////
package ipf_pkg;

	// Register bus geometry
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned LVL_W  = 3;
	localparam int unsigned NUM_SRC = 4;

	// Register word addresses
	localparam logic [3:0] EXT_INT1_PRIORITY_CTL_ADDR      = 4'h0;
	localparam logic [3:0] TIMER_COMPARE_PRIORITY_CTL_ADDR = 4'h1;

	// Field positions (low bit of each 3-bit field)
	localparam int unsigned EXT_INT1_PRIORITY_LSB    = 0;
	localparam int unsigned TIMER4_PRIORITY_LSB      = 12;
	localparam int unsigned COMPARE_CH4_PRIORITY_LSB = 8;
	localparam int unsigned COMPARE_CH3_PRIORITY_LSB = 4;

	// Source numbering on the request and status vectors
	localparam int unsigned SRC_EXT_INT1 = 0;
	localparam int unsigned SRC_TIMER4   = 1;
	localparam int unsigned SRC_CMP_CH4  = 2;
	localparam int unsigned SRC_CMP_CH3  = 3;

	// Priority codes
	localparam logic [2:0] PRIO_RESET    = 3'h4;
	localparam logic [2:0] PRIO_DISABLED = 3'h0;
	localparam logic [2:0] PRIO_LOWEST   = 3'h1;
	localparam logic [2:0] PRIO_HIGHEST  = 3'h7;

	// Idle value of the read data bus
	localparam logic [15:0] RDATA_IDLE = 16'h0000;

	// A level of zero marks a disabled source
	function automatic logic prio_enabled(input logic [2:0] lvl);
		return lvl != PRIO_DISABLED;
	endfunction

	// Larger of two levels
	function automatic logic [2:0] prio_max(input logic [2:0] a, input logic [2:0] b);
		return (a > b) ? a : b;
	endfunction

endpackage

// File: logic/ipf_field.sv
`timescale 1ns/1ps
// One 3-bit priority field with its enabled flag
module ipf_field
	import ipf_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Write side
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_data,
	// Field state
	output logic      [2:0] level_q,
	output logic            enabled_q
);

	logic [2:0] level_d;
	logic       enabled_d;

	// Next value: write replaces the field
	assign level_d   = wr_en ? wr_data : level_q;
	assign enabled_d = prio_enabled(level_d);

	// Field storage, level 4 out of reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level_q   <= PRIO_RESET;
			enabled_q <= 1'b1;
		end else begin
			level_q   <= level_d;
			enabled_q <= enabled_d;
		end
	end

endmodule // ipf_field

// File: logic/ipf_prio_regs.sv
`timescale 1ns/1ps
// Priority register bank for four interrupt sources
module ipf_prio_regs
	import ipf_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Raw source requests
	input  wire logic [3:0]  src_req,
	// Per-source priority levels
	output logic      [2:0]  ext_int1_priority,
	output logic      [2:0]  timer4_priority,
	output logic      [2:0]  compare_ch4_priority,
	output logic      [2:0]  compare_ch3_priority,
	// Per-source status and overall top level toward the arbiter
	output logic      [3:0]  src_enabled,
	output logic      [3:0]  src_req_gated,
	output logic      [2:0]  top_level
);

	//////////////////////////////////////////////////////////////////////////
	// Address decode

	logic        sel_ext;
	logic        sel_tcp;
	logic        wr_ext;
	logic        wr_tcp;

	// Register selects and write strobes
	assign sel_ext = reg_addr == EXT_INT1_PRIORITY_CTL_ADDR;
	assign sel_tcp = reg_addr == TIMER_COMPARE_PRIORITY_CTL_ADDR;
	assign wr_ext  = reg_wr & sel_ext;
	assign wr_tcp  = reg_wr & sel_tcp;

	//////////////////////////////////////////////////////////////////////////
	// Priority fields

	logic [2:0] lvl_ext;
	logic [2:0] lvl_t4;
	logic [2:0] lvl_c4;
	logic [2:0] lvl_c3;
	logic [3:0] en;

	// External interrupt 1 field, only bits 2..0 are stored
	ipf_field u_ext (
		.clk       (clk),
		.arst_n    (arst_n),
		.wr_en     (wr_ext),
		.wr_data   (reg_wdata[EXT_INT1_PRIORITY_LSB +: LVL_W]),
		.level_q   (lvl_ext),
		.enabled_q (en[SRC_EXT_INT1])
	);

	// Timer 4 field
	ipf_field u_t4 (
		.clk       (clk),
		.arst_n    (arst_n),
		.wr_en     (wr_tcp),
		.wr_data   (reg_wdata[TIMER4_PRIORITY_LSB +: LVL_W]),
		.level_q   (lvl_t4),
		.enabled_q (en[SRC_TIMER4])
	);

	// Compare channel 4 field
	ipf_field u_c4 (
		.clk       (clk),
		.arst_n    (arst_n),
		.wr_en     (wr_tcp),
		.wr_data   (reg_wdata[COMPARE_CH4_PRIORITY_LSB +: LVL_W]),
		.level_q   (lvl_c4),
		.enabled_q (en[SRC_CMP_CH4])
	);

	// Compare channel 3 field
	ipf_field u_c3 (
		.clk       (clk),
		.arst_n    (arst_n),
		.wr_en     (wr_tcp),
		.wr_data   (reg_wdata[COMPARE_CH3_PRIORITY_LSB +: LVL_W]),
		.level_q   (lvl_c3),
		.enabled_q (en[SRC_CMP_CH3])
	);

	// Levels leave straight from the field flops, code equals level
	assign ext_int1_priority    = lvl_ext;
	assign timer4_priority      = lvl_t4;
	assign compare_ch4_priority = lvl_c4;
	assign compare_ch3_priority = lvl_c3;
	assign src_enabled          = en;

	//////////////////////////////////////////////////////////////////////////
	// Read path

	logic [15:0] ext_word;
	logic [15:0] tcp_word;
	logic [15:0] rd_mux;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	// Unimplemented bits are tied to zero in the read words
	assign ext_word = {13'h0000, lvl_ext};
	assign tcp_word = {1'b0, lvl_t4, 1'b0, lvl_c4, 1'b0, lvl_c3, 4'h0};
	assign rd_mux   = sel_ext ? ext_word : (sel_tcp ? tcp_word : RDATA_IDLE);
	assign rdata_d  = reg_rd ? rd_mux : RDATA_IDLE;

	// Read data stand one cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= RDATA_IDLE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	//////////////////////////////////////////////////////////////////////////
	// Request gating

	logic [3:0] gated_d;
	logic [3:0] gated_q;
	logic [2:0] top_d;
	logic [2:0] top_q;
	logic [2:0] g_ext;
	logic [2:0] g_t4;
	logic [2:0] g_c4;
	logic [2:0] g_c3;

	// Disabled sources never pass a request
	assign gated_d = src_req & en;
	assign g_ext   = gated_d[SRC_EXT_INT1] ? lvl_ext : PRIO_DISABLED;
	assign g_t4    = gated_d[SRC_TIMER4] ? lvl_t4 : PRIO_DISABLED;
	assign g_c4    = gated_d[SRC_CMP_CH4] ? lvl_c4 : PRIO_DISABLED;
	assign g_c3    = gated_d[SRC_CMP_CH3] ? lvl_c3 : PRIO_DISABLED;
	// Highest level among live requests, zero when none
	assign top_d   = prio_max(prio_max(g_ext, g_t4), prio_max(g_c4, g_c3));

	// Registered request status
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gated_q <= 4'h0;
			top_q   <= PRIO_DISABLED;
		end else begin
			gated_q <= gated_d;
			top_q   <= top_d;
		end
	end

	assign src_req_gated = gated_q;
	assign top_level     = top_q;

	//////////////////////////////////////////////////////////////////////////
	// Checks

	logic seen_q;

	// Marks the cycles after the first edge out of reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= 1'b1;
		end
	end

	// Write and read strobes of the external field
	sequence ext_write_s;
		reg_wr && sel_ext;
	endsequence

	sequence ext_read_s;
		reg_rd && sel_ext;
	endsequence

	unimpl_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
		ext_read_s |=> reg_rdata[15:3] == 13'h0000)
		else $error("unimplemented bits read nonzero");

	field_write_a: assert property (@(posedge clk) disable iff (!arst_n)
		ext_write_s |=> ext_int1_priority == $past(reg_wdata[2:0]))
		else $error("priority field did not take write");

	field_read_a: assert property (@(posedge clk) disable iff (!arst_n)
		ext_read_s |=> reg_rdata[2:0] == $past(ext_int1_priority))
		else $error("priority field read back wrong");

	top_seven_a: assert property (@(posedge clk) disable iff (!arst_n)
		(src_req[SRC_EXT_INT1] && ext_int1_priority == PRIO_HIGHEST) |=> top_level == PRIO_HIGHEST)
		else $error("level 7 request not reported highest");

	level_one_a: assert property (@(posedge clk) disable iff (!arst_n)
		(src_req == 4'h1 && ext_int1_priority == PRIO_LOWEST) |=> top_level == PRIO_LOWEST)
		else $error("level 1 request reported wrong");

	disabled_block_a: assert property (@(posedge clk) disable iff (!arst_n)
		(ext_int1_priority == PRIO_DISABLED) |=> !src_req_gated[SRC_EXT_INT1])
		else $error("disabled source passed a request");

	disabled_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
		(ext_write_s ##1 ext_int1_priority == PRIO_DISABLED) |-> !src_enabled[SRC_EXT_INT1])
		else $error("disabled source still flagged enabled");

	reset_level_a: assert property (@(posedge clk) disable iff (!arst_n)
		!seen_q |-> (ext_int1_priority == PRIO_RESET && timer4_priority == PRIO_RESET
			&& compare_ch4_priority == PRIO_RESET && compare_ch3_priority == PRIO_RESET))
		else $error("priority field not level 4 after reset");

	rdata_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
		!reg_rd |=> reg_rdata == RDATA_IDLE)
		else $error("read data not idle without read");

	disabled_top_a: assert property (@(posedge clk) disable iff (!arst_n)
		(src_req == 4'h1 && ext_int1_priority == PRIO_DISABLED) |=> top_level == PRIO_DISABLED)
		else $error("disabled source reported as top level");

	level_equal_a: assert property (@(posedge clk) disable iff (!arst_n)
		(src_req == 4'h1 && prio_enabled(ext_int1_priority)) |=> top_level == $past(ext_int1_priority))
		else $error("lone request level differs from its code");

endmodule // ipf_prio_regs

// File: testbench/interrupt_priority_fields_tb_top.sv
`timescale 1ns/1ps
module interrupt_priority_fields_tb_top;
	import ipf_pkg::*;

	logic        clk;
	logic        arst_n;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic [3:0]  src_req;
	logic [2:0]  ext_int1_priority;
	logic [2:0]  timer4_priority;
	logic [2:0]  compare_ch4_priority;
	logic [2:0]  compare_ch3_priority;
	logic [3:0]  src_enabled;
	logic [3:0]  src_req_gated;
	logic [2:0]  top_level;
	int          error_cnt;
	int          num_checks;

	ipf_prio_regs i_ipf_prio_regs (
		.clk                  (clk),
		.arst_n               (arst_n),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_rdata            (reg_rdata),
		.src_req              (src_req),
		.ext_int1_priority    (ext_int1_priority),
		.timer4_priority      (timer4_priority),
		.compare_ch4_priority (compare_ch4_priority),
		.compare_ch3_priority (compare_ch3_priority),
		.src_enabled          (src_enabled),
		.src_req_gated        (src_req_gated),
		.top_level            (top_level)
	);

	// 40 MHz clock
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	//////////////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// Register bus cycles
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata, exp);
	endtask

	// Let request gating settle
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#(25 * 5000);
		error_cnt++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		arst_n    = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		src_req   = 4'h0;
		error_cnt  = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;

		// Reset values
		rd(EXT_INT1_PRIORITY_CTL_ADDR, 16'h0004);
		rd(TIMER_COMPARE_PRIORITY_CTL_ADDR, 16'h4440);
		check("src_enabled", {12'h000, src_enabled}, 16'h000f);
		$display("test reset done");

		// All ones, unimplemented bits dropped, read right after write
		wr(EXT_INT1_PRIORITY_CTL_ADDR, 16'hffff);
		rd(EXT_INT1_PRIORITY_CTL_ADDR, 16'h0007);
		check("ext_int1_priority", {13'h0, ext_int1_priority}, 16'h0007);
		wr(TIMER_COMPARE_PRIORITY_CTL_ADDR, 16'hffff);
		rd(TIMER_COMPARE_PRIORITY_CTL_ADDR, 16'h7770);
		wr(4'h5, 16'hffff);
		rd(4'h5, 16'h0000);
		$display("test layout done");

		// Every code of the ext int1 field
		for (int v = 0; v < 8; v++) begin
			wr(EXT_INT1_PRIORITY_CTL_ADDR, 16'(v));
			check("ext_int1_priority", {13'h0, ext_int1_priority}, 16'(v));
			check("src_enabled0", {15'h0, src_enabled[0]}, {15'h0, v != 0});
		end
		$display("test codes done");

		// Gating with ext int1 disabled, then at top level
		@(posedge clk);
		src_req <= 4'hf;
		wr(TIMER_COMPARE_PRIORITY_CTL_ADDR, 16'h2510);
		wr(EXT_INT1_PRIORITY_CTL_ADDR, 16'h0000);
		settle();
		check("src_req_gated", {12'h0, src_req_gated}, 16'h000e);
		check("top_level", {13'h0, top_level}, 16'h0005);
		wr(EXT_INT1_PRIORITY_CTL_ADDR, 16'h0007);
		settle();
		check("src_req_gated", {12'h0, src_req_gated}, 16'h000f);
		check("top_level", {13'h0, top_level}, 16'h0007);
		@(posedge clk);
		src_req <= 4'h8;
		settle();
		check("top_level", {13'h0, top_level}, 16'h0001);
		check("compare_ch3_priority", {13'h0, compare_ch3_priority}, 16'h0001);
		check("timer4_priority", {13'h0, timer4_priority}, 16'h0002);
		check("compare_ch4_priority", {13'h0, compare_ch4_priority}, 16'h0005);
		// Lone ext int1 request at level 1, then disabled
		wr(EXT_INT1_PRIORITY_CTL_ADDR, 16'h0001);
		@(posedge clk);
		src_req <= 4'h1;
		settle();
		check("top_level", {13'h0, top_level}, 16'h0001);
		check("src_req_gated", {12'h0, src_req_gated}, 16'h0001);
		wr(EXT_INT1_PRIORITY_CTL_ADDR, 16'h0000);
		settle();
		check("top_level", {13'h0, top_level}, 16'h0000);
		check("src_req_gated", {12'h0, src_req_gated}, 16'h0000);
		@(posedge clk);
		src_req <= 4'h0;
		settle();
		check("top_level", {13'h0, top_level}, 16'h0000);
		$display("test gating done");

		// Reset in mid-run reloads every field
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd(EXT_INT1_PRIORITY_CTL_ADDR, 16'h0004);
		rd(TIMER_COMPARE_PRIORITY_CTL_ADDR, 16'h4440);
		check("src_enabled", {12'h000, src_enabled}, 16'h000f);
		$display("test second reset done");

		report_and_stop();
	end

endmodule // interrupt_priority_fields_tb_top
